/* xqt_pkg.sv */
package xqt_pkg;

  // Bus geometry
  localparam int ADDR_W = 9;
  localparam int IDX_W = 7;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // Query indices; byte address is four times the index
  localparam logic [IDX_W-1:0] SIG_IDX = 7'h39;
  localparam logic [IDX_W-1:0] MAJOR_IDX = 7'h3c;
  localparam logic [IDX_W-1:0] MINOR_IDX = 7'h3d;
  localparam logic [IDX_W-1:0] FEAT_IDX = 7'h3e;
  localparam logic [IDX_W-1:0] SUSP_IDX = 7'h42;
  localparam logic [IDX_W-1:0] BSM_IDX = 7'h43;
  localparam logic [IDX_W-1:0] VCC_IDX = 7'h45;
  localparam logic [IDX_W-1:0] VPP_IDX = 7'h46;
  localparam logic [IDX_W-1:0] PCNT_IDX = 7'h47;
  localparam logic [IDX_W-1:0] PDESC_IDX = 7'h48;
  localparam logic [IDX_W-1:0] NEXT_IDX1 = 7'h1;
  localparam logic [IDX_W-1:0] NEXT_IDX2 = 7'h2;
  localparam logic [IDX_W-1:0] NEXT_IDX3 = 7'h3;

  // Own control and status words
  localparam logic [IDX_W-1:0] CTRL_IDX = 7'h60;
  localparam logic [IDX_W-1:0] STAT_IDX = 7'h61;
  localparam int CTRL_GUARD_BIT = 0;
  localparam int STAT_TBLWR_BIT = 0;
  localparam int STAT_UNMAP_BIT = 1;
  localparam int STAT_LAST_LSB = 8;
  localparam logic CTRL_GUARD_RST = 1'b1;
  localparam logic [IDX_W-1:0] LAST_IDX_RST = 7'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0;

  // Table contents
  localparam logic [BYTE_W-1:0] SIG_B0 = 8'h50;
  localparam logic [BYTE_W-1:0] SIG_B1 = 8'h52;
  localparam logic [BYTE_W-1:0] SIG_B2 = 8'h49;
  localparam logic [DATA_W-1:0] FEAT_WORD = 32'h0000_03e6;
  localparam logic [BYTE_W-1:0] SUSP_B = 8'h01;
  localparam logic [15:0] BSM_WORD = 16'h0003;
  localparam logic [BYTE_W-1:0] VCC_B = 8'h18;
  localparam logic [BYTE_W-1:0] VPP_B = 8'hc0;
  localparam logic [BYTE_W-1:0] PCNT_B = 8'h01;
  localparam logic [DATA_W-1:0] PDESC_WORD = 32'h0303_0080;
  localparam logic [BYTE_W-1:0] ZERO_B = 8'h00;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;

endpackage : xqt_pkg

/* query_lookup_if.sv */
`timescale 1ns/1ps
interface query_lookup_if;
  logic [xqt_pkg::IDX_W-1:0] idx;
  logic [xqt_pkg::BYTE_W-1:0] data;
  logic hit;
  modport requester (output idx, input data, input hit);
  modport table_side (input idx, output data, output hit);
endinterface : query_lookup_if

/* query_table.sv */
`timescale 1ns/1ps
module query_table #(
  parameter logic [xqt_pkg::BYTE_W-1:0] MAJOR_CHAR = 8'h41,
  parameter logic [xqt_pkg::BYTE_W-1:0] MINOR_CHAR = 8'h30
) (
  // Lookup
  query_lookup_if.table_side lk
);
  import xqt_pkg::*;

  // Pure constant decode: no state, so reset and writes cannot alter it
  always_comb begin
    lk.hit = 1'b1;
    case (lk.idx)
      SIG_IDX: lk.data = SIG_B0;
      SIG_IDX + NEXT_IDX1: lk.data = SIG_B1;
      SIG_IDX + NEXT_IDX2: lk.data = SIG_B2;
      MAJOR_IDX: lk.data = MAJOR_CHAR;
      MINOR_IDX: lk.data = MINOR_CHAR;
      FEAT_IDX: lk.data = FEAT_WORD[7:0];
      FEAT_IDX + NEXT_IDX1: lk.data = FEAT_WORD[15:8];
      FEAT_IDX + NEXT_IDX2: lk.data = FEAT_WORD[23:16];
      FEAT_IDX + NEXT_IDX3: lk.data = FEAT_WORD[31:24];
      SUSP_IDX: lk.data = SUSP_B;
      BSM_IDX: lk.data = BSM_WORD[7:0];
      BSM_IDX + NEXT_IDX1: lk.data = BSM_WORD[15:8];
      VCC_IDX: lk.data = VCC_B;
      VPP_IDX: lk.data = VPP_B;
      PCNT_IDX: lk.data = PCNT_B;
      PDESC_IDX: lk.data = PDESC_WORD[7:0];
      PDESC_IDX + NEXT_IDX1: lk.data = PDESC_WORD[15:8];
      PDESC_IDX + NEXT_IDX2: lk.data = PDESC_WORD[23:16];
      PDESC_IDX + NEXT_IDX3: lk.data = PDESC_WORD[31:24];
      default: begin
        lk.hit = 1'b0;
        lk.data = ZERO_B;
      end
    endcase
  end

endmodule : query_table

/* sticky_flag.sv */
`timescale 1ns/1ps
module sticky_flag (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Event and clear
  input wire logic set_evt,
  input wire logic clr_req,
  output logic flag_ff
);

  // Set wins so an event in the clearing cycle is kept
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flag_ff <= 1'b0;
    end else if (set_evt) begin
      flag_ff <= 1'b1;
    end else if (clr_req) begin
      flag_ff <= 1'b0;
    end
  end

  set_wins_a: assert property (@(posedge clock) disable iff (sys_rst) set_evt |=> flag_ff)
    else $error("sticky flag lost an event");
  clear_done_a: assert property (@(posedge clock) disable iff (sys_rst)
    clr_req && !set_evt |=> !flag_ff)
    else $error("sticky flag did not clear");

endmodule : sticky_flag

/* flash_extended_query_table.sv */
`timescale 1ns/1ps
// Behaviour
// - Query indices 39h, 3Ah, 3Bh return 50h, 52h, 49h, the table signature.
// - Major version character at index 3Ch, minor version character at 3Dh.
// - Feature word at 3Eh-41h, low byte first: E6h, 03h, 00h, 00h.
// - Feature bits 0, 3, 4 read zero; bits 1, 2, 5 to 9 read one.
// - Index 42h returns 01h: program allowed during erase suspend.
// - Indices 43h, 44h return block status mask 0003h.
// - Index 45h returns logic supply voltage code 18h.
// - Index 46h returns programming supply voltage code C0h.
// - Index 47h returns protection field count 01h.
// - Indices 48h-4Bh return protection descriptor 80h, 00h, 03h, 03h.
module flash_extended_query_table #(
  // Arbitrary value
  parameter logic [xqt_pkg::BYTE_W-1:0] MAJOR_CHAR = 8'h41,
  // Arbitrary value
  parameter logic [xqt_pkg::BYTE_W-1:0] MINOR_CHAR = 8'h30
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [xqt_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [xqt_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [xqt_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest
);
  import xqt_pkg::*;

  bus_state_e state_ff;
  bus_state_e nxt_state;
  logic waitreq_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic guard_ff;
  logic [IDX_W-1:0] last_idx_ff;
  logic tblwr_ff;
  logic unmap_ff;
  logic aligned;
  logic is_table;
  logic is_ctrl;
  logic is_stat;
  logic mapped;
  logic req;
  logic accept;
  logic stat_clr_tblwr;
  logic stat_clr_unmap;
  logic set_tblwr;
  logic set_unmap;
  logic rd_req;

  query_lookup_if lk ();

  query_table #(
    .MAJOR_CHAR(MAJOR_CHAR),
    .MINOR_CHAR(MINOR_CHAR)
  ) u_table (
    .lk(lk.table_side)
  );

  assign lk.idx = avs_address[ADDR_W-1:IDX_LSB];
  assign aligned = (avs_address[IDX_LSB-1:0] == WORD_ALIGN);
  assign is_table = aligned && lk.hit;
  assign is_ctrl = aligned && (lk.idx == CTRL_IDX);
  assign is_stat = aligned && (lk.idx == STAT_IDX);
  assign mapped = is_table || is_ctrl || is_stat;
  assign req = avs_read || avs_write;
  // Write takes effect only at the edge that sees waitrequest low
  assign accept = (state_ff == BUS_ANSWER) && req;
  assign rd_req = (state_ff == BUS_IDLE) && avs_read && aligned;

  // Handshake: one wait state, then a single answer cycle
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BUS_IDLE: begin
        if (req) begin
          nxt_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        nxt_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Held high in reset so no request is taken early
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      waitreq_ff <= 1'b1;
    end else begin
      waitreq_ff <= (nxt_state != BUS_ANSWER);
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    nxt_rdata = RDATA_RST;
    if (is_table) begin
      nxt_rdata[BYTE_W-1:0] = lk.data;
    end else if (is_ctrl) begin
      nxt_rdata[CTRL_GUARD_BIT] = guard_ff;
    end else if (is_stat) begin
      nxt_rdata[STAT_TBLWR_BIT] = tblwr_ff;
      nxt_rdata[STAT_UNMAP_BIT] = unmap_ff;
      nxt_rdata[STAT_LAST_LSB +: IDX_W] = last_idx_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_ff <= RDATA_RST;
    end else if ((state_ff == BUS_IDLE) && avs_read) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Control word: guard enables capture of writes aimed at the table
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      guard_ff <= CTRL_GUARD_RST;
    end else if (accept && avs_write && is_ctrl && avs_byteenable[0]) begin
      guard_ff <= avs_writedata[CTRL_GUARD_BIT];
    end
  end

  // Last table index served, for software tracing of query walks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_idx_ff <= LAST_IDX_RST;
    end else if (accept && avs_read && is_table) begin
      last_idx_ff <= lk.idx;
    end
  end

  // Table writes are acknowledged but never stored
  assign set_tblwr = accept && avs_write && is_table && guard_ff;
  assign set_unmap = accept && !mapped;
  assign stat_clr_tblwr = accept && avs_write && is_stat && avs_byteenable[0]
    && avs_writedata[STAT_TBLWR_BIT];
  assign stat_clr_unmap = accept && avs_write && is_stat && avs_byteenable[0]
    && avs_writedata[STAT_UNMAP_BIT];

  sticky_flag u_tblwr_flag (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_evt(set_tblwr),
    .clr_req(stat_clr_tblwr),
    .flag_ff(tblwr_ff)
  );

  sticky_flag u_unmap_flag (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_evt(set_unmap),
    .clr_req(stat_clr_unmap),
    .flag_ff(unmap_ff)
  );

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = waitreq_ff;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  handshake_one_wait_a: assert property ((state_ff == BUS_IDLE) && req
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("answer not given after one wait state");

  sig_first_a: assert property (rd_req && lk.idx == SIG_IDX
    |=> !avs_waitrequest && avs_readdata[7:0] == SIG_B0)
    else $error("signature byte 0 wrong");
  sig_second_a: assert property (rd_req && lk.idx == SIG_IDX + NEXT_IDX1
    |=> avs_readdata[7:0] == SIG_B1)
    else $error("signature byte 1 wrong");
  sig_third_a: assert property (rd_req && lk.idx == SIG_IDX + NEXT_IDX2
    |=> avs_readdata[7:0] == SIG_B2)
    else $error("signature byte 2 wrong");

  major_version_a: assert property (rd_req && lk.idx == MAJOR_IDX
    |=> avs_readdata[7:0] == MAJOR_CHAR)
    else $error("major version wrong");
  minor_version_a: assert property (rd_req && lk.idx == MINOR_IDX
    |=> avs_readdata[7:0] == MINOR_CHAR)
    else $error("minor version wrong");

  feat_low_a: assert property (rd_req && lk.idx == FEAT_IDX
    |=> avs_readdata[7:0] == 8'he6)
    else $error("feature byte 0 wrong");
  feat_second_a: assert property (rd_req && lk.idx == FEAT_IDX + NEXT_IDX1
    |=> avs_readdata[7:0] == 8'h03 && avs_readdata[7:2] == 6'h0)
    else $error("feature byte 1 wrong");
  feat_upper_a: assert property (rd_req
    && (lk.idx == FEAT_IDX + NEXT_IDX2 || lk.idx == FEAT_IDX + NEXT_IDX3)
    |=> avs_readdata[7:0] == ZERO_B)
    else $error("reserved feature bytes not zero");

  feat_unsupported_a: assert property (rd_req && lk.idx == FEAT_IDX
    |=> !avs_readdata[0] && !avs_readdata[3] && !avs_readdata[4])
    else $error("unsupported feature reads one");
  feat_supported_a: assert property (rd_req && lk.idx == FEAT_IDX
    |=> avs_readdata[1] && avs_readdata[2] && (&avs_readdata[7:5]))
    else $error("supported feature reads zero");
  feat_sync_a: assert property (rd_req && lk.idx == FEAT_IDX + NEXT_IDX1
    |=> avs_readdata[0] && avs_readdata[1])
    else $error("read or simultaneous feature bit wrong");

  suspend_ops_a: assert property (rd_req && lk.idx == SUSP_IDX
    |=> avs_readdata[7:0] == SUSP_B)
    else $error("after suspend byte wrong");

  block_mask_a: assert property (rd_req && lk.idx == BSM_IDX
    |=> avs_readdata[7:0] == 8'h03)
    else $error("block status mask low wrong");
  block_mask_hi_a: assert property (rd_req && lk.idx == BSM_IDX + NEXT_IDX1
    |=> avs_readdata[7:0] == ZERO_B)
    else $error("block status mask high wrong");

  vcc_code_a: assert property (rd_req && lk.idx == VCC_IDX
    |=> avs_readdata[7:0] == VCC_B)
    else $error("logic supply code wrong");

  vpp_code_a: assert property (rd_req && lk.idx == VPP_IDX
    |=> avs_readdata[7:0] == VPP_B)
    else $error("program supply code wrong");

  prot_count_a: assert property (rd_req && lk.idx == PCNT_IDX
    |=> avs_readdata[7:0] == PCNT_B)
    else $error("protection field count wrong");

  prot_desc_lo_a: assert property (rd_req && lk.idx == PDESC_IDX
    |=> avs_readdata[7:0] == 8'h80)
    else $error("protection lock address low wrong");
  prot_desc_mid_a: assert property (rd_req && lk.idx == PDESC_IDX + NEXT_IDX1
    |=> avs_readdata[7:0] == ZERO_B)
    else $error("protection lock address high wrong");
  prot_desc_hi_a: assert property (rd_req
    && (lk.idx == PDESC_IDX + NEXT_IDX2 || lk.idx == PDESC_IDX + NEXT_IDX3)
    |=> avs_readdata[7:0] == 8'h03)
    else $error("protection size code wrong");

  upper_lanes_a: assert property (rd_req && lk.hit
    |=> avs_readdata[DATA_W-1:BYTE_W] == '0)
    else $error("upper data lanes not zero");
  table_constant_a: assert property ($fell(sys_rst) ##[1:8] rd_req
    && lk.idx == SIG_IDX + NEXT_IDX1 |=> avs_readdata[7:0] == SIG_B1)
    else $error("table byte changed by reset");
  write_no_effect_a: assert property (accept && avs_write && is_table
    ##[1:2] rd_req && lk.idx == FEAT_IDX |=> avs_readdata[7:0] == FEAT_WORD[7:0])
    else $error("table read changed after write");

  unmapped_zero_a: assert property ((state_ff == BUS_IDLE) && avs_read && !mapped
    |=> avs_readdata == RDATA_RST ##1 unmap_ff)
    else $error("unmapped read not zero or not flagged");
  ascii_version_a: assert property (rd_req
    && (lk.idx == MAJOR_IDX || lk.idx == MINOR_IDX) |=> !avs_readdata[BYTE_W-1])
    else $error("version character not ascii");

  // Bus contract
  reset_idle_a: assert property ($past(sys_rst)
    |-> avs_waitrequest && avs_readdata == RDATA_RST)
    else $error("bus not idle after reset");
  flags_reset_a: assert property ($past(sys_rst) |-> !tblwr_ff && !unmap_ff
    && guard_ff == CTRL_GUARD_RST && last_idx_ff == LAST_IDX_RST)
    else $error("own registers not reset");
  answer_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  no_spurious_answer_a: assert property (!avs_waitrequest
    |-> $past((state_ff == BUS_IDLE) && req))
    else $error("answer without a request");
  idle_no_answer_a: assert property ((state_ff == BUS_IDLE) && !req
    |=> avs_waitrequest)
    else $error("answer while idle");
  answer_write_a: assert property ((state_ff == BUS_IDLE) && avs_write
    |=> !avs_waitrequest && $stable(avs_readdata))
    else $error("write answer wrong");
  // Read data must stand until the next read, writes included
  readdata_hold_a: assert property (!((state_ff == BUS_IDLE) && avs_read)
    |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  misaligned_zero_a: assert property ((state_ff == BUS_IDLE) && avs_read && !aligned
    |=> avs_readdata == RDATA_RST)
    else $error("misaligned read not zero");

  // Table decode
  hit_range_a: assert property (lk.hit
    |-> lk.idx >= SIG_IDX && lk.idx <= PDESC_IDX + NEXT_IDX3)
    else $error("table answers outside its range");
  miss_data_zero_a: assert property (!lk.hit |-> lk.data == ZERO_B)
    else $error("table miss gives data");
  table_miss_zero_a: assert property (rd_req && !mapped
    |=> avs_readdata == RDATA_RST)
    else $error("unmapped aligned read not zero");

  // Control and status words
  ctrl_read_a: assert property (rd_req && is_ctrl
    |=> avs_readdata[CTRL_GUARD_BIT] == $past(guard_ff)
      && avs_readdata[DATA_W-1:CTRL_GUARD_BIT+1] == '0)
    else $error("control word read wrong");
  guard_write_a: assert property (accept && avs_write && is_ctrl && avs_byteenable[0]
    |=> guard_ff == $past(avs_writedata[CTRL_GUARD_BIT]))
    else $error("guard not written");
  guard_hold_a: assert property (!(accept && avs_write && is_ctrl && avs_byteenable[0])
    |=> $stable(guard_ff))
    else $error("guard changed without a write");
  stat_read_a: assert property (rd_req && is_stat
    |=> avs_readdata[STAT_TBLWR_BIT] == $past(tblwr_ff)
      && avs_readdata[STAT_UNMAP_BIT] == $past(unmap_ff)
      && avs_readdata[STAT_LAST_LSB +: IDX_W] == $past(last_idx_ff))
    else $error("status word read wrong");
  stat_upper_zero_a: assert property (rd_req && is_stat
    |=> avs_readdata[DATA_W-1:STAT_LAST_LSB+IDX_W] == '0)
    else $error("status upper bits not zero");
  last_idx_track_a: assert property (accept && avs_read && is_table
    |=> last_idx_ff == $past(lk.idx))
    else $error("last index not tracked");
  table_write_flag_a: assert property (accept && avs_write && is_table && guard_ff
    |=> tblwr_ff)
    else $error("guarded table write not flagged");
  guard_gates_flag_a: assert property (accept && avs_write && is_table && !guard_ff
    && !tblwr_ff |=> !tblwr_ff)
    else $error("table write flagged with guard off");
  unmapped_write_flag_a: assert property (accept && avs_write && !mapped
    |=> unmap_ff)
    else $error("unmapped write not flagged");
  tblwr_clear_a: assert property (accept && avs_write && is_stat && avs_byteenable[0]
    && avs_writedata[STAT_TBLWR_BIT] |=> !tblwr_ff)
    else $error("table write flag not cleared");
  unmap_clear_a: assert property (accept && avs_write && is_stat && avs_byteenable[0]
    && avs_writedata[STAT_UNMAP_BIT] |=> !unmap_ff)
    else $error("unmapped flag not cleared");

endmodule : flash_extended_query_table

/* xqt_host.sv */
`timescale 1ns/1ps
module xqt_host (
  // Clock
  input wire logic clock,
  // Avalon-MM master
  output logic [xqt_pkg::ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [xqt_pkg::DATA_W-1:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [xqt_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest
);
  import xqt_pkg::*;

  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'h0;
  end

  // Released lines show the inverse, so stale values never pass as answers
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
      input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata,
      output logic ok);
    int n;
    ok = 1'b0;
    rdata = '0;
    @(posedge clock);
    avs_address <= addr;
    avs_writedata <= wdata;
    avs_byteenable <= 4'hf;
    avs_read <= ~wr;
    avs_write <= wr;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) begin
        rdata = avs_readdata;
        ok = 1'b1;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~addr;
    avs_writedata <= ~wdata;
  endtask : xfer
endmodule : xqt_host

/* flash_extended_query_table_tb.sv */
`timescale 1ns/1ps
module flash_extended_query_table_tb;
  import xqt_pkg::*;
  // Arbitrary version characters
  localparam logic [7:0] MAJ = 8'h37;
  localparam logic [7:0] MIN = 8'h34;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic [7:0] exp_tab [19] = '{8'h50, 8'h52, 8'h49, MAJ, MIN, 8'he6, 8'h03, 8'h00,
    8'h00, 8'h01, 8'h03, 8'h00, 8'h18, 8'hc0, 8'h01, 8'h80, 8'h00, 8'h03, 8'h03};

  flash_extended_query_table #(.MAJOR_CHAR(MAJ), .MINOR_CHAR(MIN))
      i_flash_extended_query_table (.clock(clock), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  xqt_host i_xqt_host (.clock(clock), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

  initial begin
    forever #2.5 clock = ~clock;
  end

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic acc(input logic wr, input logic [8:0] addr, input logic [31:0] wd);
    logic ok;
    i_xqt_host.xfer(wr, addr, wd, rd, ok);
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED at %0t: no answer at %h", $time, addr);
      close_out();
    end
  endtask : acc

  // Table bytes in order, one per word on the low lane
  task automatic t_table;
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, 9'h0e4 + 9'(4 * i), '0);
      check(rd, {24'h0, exp_tab[i]}, "table byte");
    end
    for (int i = 10; i < 19; i++) begin
      acc(1'b0, 9'h0e4 + 9'(4 * i), '0);
      check(rd, {24'h0, exp_tab[i]}, "table byte");
    end
    acc(1'b0, 9'h184, '0);
    check(rd & 32'h7f03, 32'h4b00, "status after table");
    $display("test table done");
  endtask : t_table

  // Writes over the table leave it untouched
  task automatic t_write;
    acc(1'b1, 9'h0f8, 32'hffff_ffff);
    acc(1'b1, 9'h0e4, 32'h0000_0000);
    acc(1'b0, 9'h0f8, '0);
    check(rd, 32'h0000_00e6, "feature low after write");
    acc(1'b0, 9'h0e4, '0);
    check(rd, 32'h0000_0050, "signature after write");
    acc(1'b0, 9'h184, '0);
    check(rd & 32'h3, 32'h1, "write seen");
    acc(1'b1, 9'h184, 32'h1);
    acc(1'b0, 9'h184, '0);
    check(rd & 32'h3, 32'h0, "write flag cleared");
    $display("test write done");
  endtask : t_write

  task automatic t_unmap;
    acc(1'b0, 9'h1fc, '0);
    check(rd, 32'h0, "unmapped read");
    acc(1'b0, 9'h0e5, '0);
    check(rd, 32'h0, "misaligned read");
    acc(1'b1, 9'h1fc, 32'h0);
    acc(1'b0, 9'h184, '0);
    check(rd & 32'h3, 32'h2, "unmapped seen");
    acc(1'b1, 9'h184, 32'h2);
    acc(1'b0, 9'h184, '0);
    check(rd & 32'h3, 32'h0, "unmapped cleared");
    $display("test unmapped done");
  endtask : t_unmap

  // Guard off: table writes are not recorded
  task automatic t_guard;
    acc(1'b1, 9'h180, 32'h0);
    acc(1'b0, 9'h180, '0);
    check(rd, 32'h0, "guard cleared");
    acc(1'b1, 9'h0e4, 32'hffff_ffff);
    acc(1'b0, 9'h184, '0);
    check(rd & 32'h3, 32'h0, "table write with guard off");
    acc(1'b0, 9'h0e4, '0);
    check(rd, 32'h0000_0050, "signature after guarded write");
    acc(1'b0, 9'h1fc, '0);
    check(rd, 32'h0, "unmapped read before reset");
    $display("test guard done");
  endtask : t_guard

  // Reset in mid-run: bus idle values, table still intact
  task automatic t_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check({31'h0, avs_waitrequest}, 32'h1, "wait in reset");
    check(avs_readdata, 32'h0, "data in reset");
    @(posedge clock);
    sys_rst <= 1'b0;
    acc(1'b0, 9'h0e8, '0);
    check(rd, 32'h0000_0052, "signature after reset");
    acc(1'b0, 9'h184, '0);
    check(rd & 32'h7f03, 32'h3a00, "status after reset");
    acc(1'b0, 9'h180, '0);
    check(rd, 32'h1, "guard after reset");
    acc(1'b0, 9'h12c, '0);
    check(rd, 32'h0000_0003, "descriptor after reset");
    $display("test reset done");
  endtask : t_reset

  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_table();
    t_write();
    t_unmap();
    t_guard();
    t_reset();
    close_out();
  end
endmodule : flash_extended_query_table_tb
